/* File: hdl/scp_pkg.sv */
// Constants, field layout and state codes for the serial control port.
// Assumes a single 40 MHz clock domain; link pins are sampled synchronously.
package scp_pkg;

    // ----------------------------------------------------------------
    // Control word layout
    // ----------------------------------------------------------------
    localparam int CTRL_WORD_W = 16;
    localparam int REG_ADDR_W  = 7;
    localparam int REG_DATA_W  = 9;

    // ----------------------------------------------------------------
    // Register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_SW_RESET = 7'h00;
    localparam logic [6:0] ADDR_PM1      = 7'h01;
    localparam logic [6:0] ADDR_PINFN    = 7'h08;
    localparam logic [6:0] ADDR_CONV     = 7'h0E;

    localparam logic [8:0] PM1_RESET   = 9'h000;
    localparam logic [8:0] PINFN_RESET = 9'h000;
    localparam logic [8:0] CONV_RESET  = 9'h100;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PM1_MIDRAIL_LSB = 0;
    localparam int PM1_BIAS_BIT    = 3;
    localparam int PM1_PLL_BIT     = 5;
    localparam int PINFN_SEL_LSB   = 0;
    localparam int PINFN_POL_BIT   = 3;
    localparam int PINFN_DIV_LSB   = 4;
    localparam int CONV_OSR_BIT    = 3;

    // ----------------------------------------------------------------
    // Link constants
    // ----------------------------------------------------------------
    localparam logic [6:0] BUS_DEV_ADDR = 7'h1A;
    localparam int         ADC_INIT_FS  = 2;

    typedef enum logic [2:0]
    {
        PIN_FN_STROBE  = 3'h0,
        PIN_FN_TEMP_OK = 3'h2,
        PIN_FN_AMUTE   = 3'h3,
        PIN_FN_PLL_CLK = 3'h4,
        PIN_FN_PLL_LCK = 3'h5
    } scp_pin_fn_t;

    typedef enum logic [2:0]
    {
        ST_IDLE      = 3'h0,
        ST_ADDR      = 3'h1,
        ST_ADDR_ACK  = 3'h2,
        ST_BYTE1     = 3'h3,
        ST_ACK1      = 3'h4,
        ST_BYTE2     = 3'h5,
        ST_ACK2      = 3'h6,
        ST_WAIT_STOP = 3'h7
    } scp_state_t;

endpackage

/* File: hdl/scp_div_if.sv */
// Carrier between the control port and its clock-out divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface scp_div_if;
    logic [1:0] div_code;
    logic       pll_rise;
    logic       pll_level;
    logic       clk_out;

    modport src
    (
        output div_code,
        output pll_rise,
        output pll_level,
        input  clk_out
    );

    modport sink
    (
        input  div_code,
        input  pll_rise,
        input  pll_level,
        output clk_out
    );
endinterface

/* File: hdl/scp_clk_div.sv */
// Divides the sampled PLL clock by 1 to 4 for the shared pin.
// Assumes the PLL clock is sampled on the system clock, edges flagged by the source.
`timescale 1ns/1ps
module scp_clk_div
    import scp_pkg::*;
#(
    parameter int CNT_W = 2
)
(
    input  wire logic mclk_in,
    input  wire logic resetn_in,
    scp_div_if.sink   div
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] half;

    // Ratio is code plus one; ratio three gives a short high phase
    // Sum formed one bit wider so divide by four does not wrap to zero
    assign half = CNT_W'(((CNT_W+1)'(div.div_code) + (CNT_W+1)'(1)) >> 1);

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cnt_q <= '0;
        end
        else if (div.pll_rise)
        begin
            if (cnt_q >= CNT_W'(div.div_code))
                cnt_q <= '0;
            else
                cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            div.clk_out <= 1'b0;
        else if (div.div_code == 2'h0)
            div.clk_out <= div.pll_level;
        else
            div.clk_out <= (cnt_q < half);
    end

    property p_div_bypass;
        @(posedge mclk_in) disable iff (!resetn_in)
        (div.div_code == 2'h0) |=> (div.clk_out == $past(div.pll_level));
    endproperty
    a_div_bypass: assert property (p_div_bypass) else $error("divide by one does not follow pll clock");

endmodule

/* File: hdl/scp_top.sv */
// Serial control port: 3-wire latched and 2-wire write-only slave links,
// register file, shared strobe/general-purpose pin and converter start-up.
// Assumes all pins are synchronous to mclk_in and the bus wire is resolved outside.
//
// How it works
// - Mode pin low selects 2-wire link, high selects 3-wire link.
// - Control word is 16 bits: 7 address bits, 9 data bits.
// - 3-wire: each serial clock rise shifts one data bit in.
// - 3-wire: strobe rise commits the last 16 shifted bits.
// - 2-wire: after start, shift address and read/write bit, MSB first.
// - Matching address is acknowledged by pulling data low one clock.
// - Wrong address or read request sends the slave back to idle.
// - Two data bytes follow, high then low, each acknowledged.
// - Stop condition ends the transfer and returns to idle.
// - Start or stop out of sequence abandons the transfer.
// - Slave answers only bus address 0011010.
// - Shared pin is general output only in 2-wire mode.
// - Pin function codes select source; polarity bit inverts it.
// - Clock-out divider divides PLL clock by one to four.
// - Any write to address zero restores all register defaults.
// - Power-on reset loads defaults into all registers.
// - Oversample bit selects 64x when clear, 128x when set.
// - Midrail field selects reference impedance; zero means off.
// - Converter output valid two sample periods after enable.
// - Register writes accepted right after reset release.
`timescale 1ns/1ps
module scp_top
    import scp_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire logic       mode_in,
    input  wire logic       serial_clock_in,
    input  wire logic       serial_data_line_in,
    output logic            serial_data_line_out,
    output logic            serial_data_line_oe_out,
    input  wire logic       latch_strobe_pin_in,
    output logic            latch_strobe_pin_out,
    output logic            latch_strobe_pin_oe_out,
    input  wire logic       temp_ok_in,
    input  wire logic       automute_active_in,
    input  wire logic       pll_clk_in,
    input  wire logic       pll_lock_in,
    input  wire logic       adc_enable_in,
    input  wire logic       fs_tick_in,
    output logic [1:0]      midrail_impedance_select_out,
    output logic            amp_bias_enable_out,
    output logic            pll_enable_out,
    output logic            oversample_select_out,
    output logic [8:0]      converter_control_out,
    output logic            sample_valid_out
);

    // ----------------------------------------------------------------
    // Pin sampling and edge detection
    // ----------------------------------------------------------------
    logic sclk_prev_q;
    logic sda_prev_q;
    logic strobe_prev_q;
    logic pll_prev_q;
    logic two_wire;
    logic three_wire;
    logic sclk_rise;
    logic sclk_fall;
    logic start_det;
    logic stop_det;
    logic strobe_rise;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sclk_prev_q   <= 1'b0;
            sda_prev_q    <= 1'b1;
            strobe_prev_q <= 1'b0;
            pll_prev_q    <= 1'b0;
        end
        else
        begin
            sclk_prev_q   <= serial_clock_in;
            sda_prev_q    <= serial_data_line_in;
            strobe_prev_q <= latch_strobe_pin_in;
            pll_prev_q    <= pll_clk_in;
        end
    end

    assign two_wire    = !mode_in;
    assign three_wire  = mode_in;
    assign sclk_rise   = serial_clock_in && !sclk_prev_q;
    assign sclk_fall   = !serial_clock_in && sclk_prev_q;
    // Data moving while clock stays high marks a bus condition
    assign start_det   = two_wire && serial_clock_in && sclk_prev_q && sda_prev_q && !serial_data_line_in;
    assign stop_det    = two_wire && serial_clock_in && sclk_prev_q && !sda_prev_q && serial_data_line_in;
    assign strobe_rise = three_wire && latch_strobe_pin_in && !strobe_prev_q;

    // ----------------------------------------------------------------
    // 3-wire shift register
    // ----------------------------------------------------------------
    logic [CTRL_WORD_W-1:0] sr3_q;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            sr3_q <= '0;
        else if (three_wire && sclk_rise)
            sr3_q <= {sr3_q[CTRL_WORD_W-2:0], serial_data_line_in};
    end

    // ----------------------------------------------------------------
    // 2-wire slave state machine
    // ----------------------------------------------------------------
    scp_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] byte_hi_q;
    logic       ack_pend_q;
    logic       sda_oe_q;
    logic       wr2_q;
    logic       addr_ok;

    // Seven address bits already shifted; current bit is read/write
    assign addr_ok = (shift_q[6:0] == BUS_DEV_ADDR) && !serial_data_line_in;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q    <= ST_IDLE;
            bit_cnt_q  <= 3'h0;
            shift_q    <= 8'h00;
            byte_hi_q  <= 8'h00;
            ack_pend_q <= 1'b0;
            sda_oe_q   <= 1'b0;
            wr2_q      <= 1'b0;
        end
        else
        begin
            wr2_q <= 1'b0;
            if (!two_wire)
            begin
                state_q    <= ST_IDLE;
                ack_pend_q <= 1'b0;
                sda_oe_q   <= 1'b0;
            end
            else if (stop_det)
            begin
                state_q    <= ST_IDLE;
                ack_pend_q <= 1'b0;
                sda_oe_q   <= 1'b0;
            end
            else if (start_det)
            begin
                // A start inside a transfer abandons it rather than restarting
                state_q    <= (state_q == ST_IDLE) ? ST_ADDR : ST_IDLE;
                bit_cnt_q  <= 3'h0;
                ack_pend_q <= 1'b0;
                sda_oe_q   <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_ADDR, ST_BYTE1, ST_BYTE2:
                    begin
                        if (sclk_rise && !ack_pend_q)
                        begin
                            shift_q   <= {shift_q[6:0], serial_data_line_in};
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7)
                            begin
                                if (state_q == ST_ADDR && !addr_ok)
                                    state_q <= ST_IDLE;
                                else
                                    ack_pend_q <= 1'b1;
                                if (state_q == ST_BYTE1)
                                    byte_hi_q <= {shift_q[6:0], serial_data_line_in};
                            end
                        end
                        else if (ack_pend_q && sclk_fall)
                        begin
                            ack_pend_q <= 1'b0;
                            sda_oe_q   <= 1'b1;
                            case (state_q)
                                ST_ADDR:  state_q <= ST_ADDR_ACK;
                                ST_BYTE1: state_q <= ST_ACK1;
                                default:  state_q <= ST_ACK2;
                            endcase
                        end
                    end
                    ST_ADDR_ACK, ST_ACK1, ST_ACK2:
                    begin
                        if (sclk_fall)
                        begin
                            sda_oe_q  <= 1'b0;
                            bit_cnt_q <= 3'h0;
                            case (state_q)
                                ST_ADDR_ACK: state_q <= ST_BYTE1;
                                ST_ACK1:     state_q <= ST_BYTE2;
                                default:
                                begin
                                    state_q <= ST_WAIT_STOP;
                                    wr2_q   <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_WAIT_STOP:
                    begin
                        state_q <= ST_WAIT_STOP;
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign serial_data_line_out    = 1'b0;
    assign serial_data_line_oe_out = sda_oe_q;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic                   wr_fire;
    logic [CTRL_WORD_W-1:0] wr_word;
    logic [REG_ADDR_W-1:0]  wr_addr;
    logic [REG_DATA_W-1:0]  wr_data;
    logic [8:0]             pm1_q;
    logic [8:0]             pinfn_q;
    logic [8:0]             conv_q;

    assign wr_fire = wr2_q || strobe_rise;
    assign wr_word = wr2_q ? {byte_hi_q, shift_q} : sr3_q;
    assign wr_addr = wr_word[CTRL_WORD_W-1:REG_DATA_W];
    assign wr_data = wr_word[REG_DATA_W-1:0];

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pm1_q   <= PM1_RESET;
            pinfn_q <= PINFN_RESET;
            conv_q  <= CONV_RESET;
        end
        else if (wr_fire)
        begin
            case (wr_addr)
                ADDR_SW_RESET:
                begin
                    pm1_q   <= PM1_RESET;
                    pinfn_q <= PINFN_RESET;
                    conv_q  <= CONV_RESET;
                end
                ADDR_PM1:   pm1_q   <= wr_data;
                ADDR_PINFN: pinfn_q <= wr_data;
                ADDR_CONV:  conv_q  <= wr_data;
                default:    pm1_q   <= pm1_q;
            endcase
        end
    end

    // Readiness of the analogue path is left to software: both fields must be set
    assign midrail_impedance_select_out = pm1_q[PM1_MIDRAIL_LSB +: 2];
    assign amp_bias_enable_out          = pm1_q[PM1_BIAS_BIT];
    assign pll_enable_out               = pm1_q[PM1_PLL_BIT];
    assign oversample_select_out        = conv_q[CONV_OSR_BIT];
    assign converter_control_out        = conv_q;

    // ----------------------------------------------------------------
    // Shared pin function
    // ----------------------------------------------------------------
    scp_div_if div_if ();
    logic [2:0] pin_sel;
    logic       pin_src;
    logic       pin_src_ok;
    logic       pin_out_q;
    logic       pin_oe_q;

    assign pin_sel            = pinfn_q[PINFN_SEL_LSB +: 3];
    assign div_if.div_code    = pinfn_q[PINFN_DIV_LSB +: 2];
    assign div_if.pll_rise    = pll_clk_in && !pll_prev_q;
    assign div_if.pll_level   = pll_clk_in;

    scp_clk_div #(
        .CNT_W (2)
    ) u_clk_div (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .div       (div_if)
    );

    always_comb
    begin
        pin_src    = 1'b0;
        pin_src_ok = 1'b1;
        case (pin_sel)
            PIN_FN_TEMP_OK: pin_src = temp_ok_in;
            PIN_FN_AMUTE:   pin_src = automute_active_in;
            PIN_FN_PLL_CLK: pin_src = div_if.clk_out;
            PIN_FN_PLL_LCK: pin_src = pll_lock_in;
            default:        pin_src_ok = 1'b0;              // Strobe input and reserved codes
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end
        else
        begin
            pin_out_q <= pin_src ^ pinfn_q[PINFN_POL_BIT];
            pin_oe_q  <= two_wire && pin_src_ok;
        end
    end

    // Mode change releases the pin at once, ahead of the registered enable
    assign latch_strobe_pin_out    = pin_out_q;
    assign latch_strobe_pin_oe_out = pin_oe_q && two_wire;

    // ----------------------------------------------------------------
    // Converter initialisation delay
    // ----------------------------------------------------------------
    logic [1:0] init_cnt_q;
    logic       valid_q;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            init_cnt_q <= 2'h0;
            valid_q    <= 1'b0;
        end
        else if (!adc_enable_in)
        begin
            init_cnt_q <= 2'h0;
            valid_q    <= 1'b0;
        end
        else if (fs_tick_in && !valid_q)
        begin
            init_cnt_q <= init_cnt_q + 2'h1;
            valid_q    <= (init_cnt_q == 2'(ADC_INIT_FS - 1));
        end
    end

    assign sample_valid_out = valid_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_three_wire_quiet;
        @(posedge mclk_in) disable iff (!resetn_in)
        three_wire |-> !serial_data_line_oe_out && !latch_strobe_pin_oe_out;
    endproperty
    a_three_wire_quiet: assert property (p_three_wire_quiet) else $error("pin driven in 3-wire mode");

    property p_shift3;
        @(posedge mclk_in) disable iff (!resetn_in)
        (three_wire && sclk_rise) |=> (sr3_q[0] == $past(serial_data_line_in)) && (sr3_q[15:1] == $past(sr3_q[14:0]));
    endproperty
    a_shift3: assert property (p_shift3) else $error("3-wire bit not shifted in");

    property p_commit3;
        @(posedge mclk_in) disable iff (!resetn_in)
        (strobe_rise && sr3_q[15:9] == ADDR_PM1) |=> (pm1_q == $past(sr3_q[8:0]));
    endproperty
    a_commit3: assert property (p_commit3) else $error("strobe did not commit word");

    property p_sw_reset;
        @(posedge mclk_in) disable iff (!resetn_in)
        (wr_fire && wr_addr == ADDR_SW_RESET) |=> (pm1_q == PM1_RESET) && (pinfn_q == PINFN_RESET) && (conv_q == CONV_RESET);
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("software reset left a register");

    property p_start_addr;
        @(posedge mclk_in) disable iff (!resetn_in)
        (start_det && state_q == ST_IDLE && !stop_det) |=> (state_q == ST_ADDR) && (bit_cnt_q == 3'h0);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not followed by address phase");

    property p_bad_addr;
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_q == ST_ADDR && sclk_rise && !ack_pend_q && bit_cnt_q == 3'h7 && !addr_ok && !start_det && !stop_det)
            |=> (state_q == ST_IDLE) ##1 !serial_data_line_oe_out;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("mismatched address not dropped");

    property p_stop_idle;
        @(posedge mclk_in) disable iff (!resetn_in)
        stop_det |=> (state_q == ST_IDLE) && !serial_data_line_oe_out;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

    property p_ack_drive;
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_q == ST_ADDR_ACK || state_q == ST_ACK1 || state_q == ST_ACK2) |-> serial_data_line_oe_out;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

    property p_write2;
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_q == ST_ACK2 && sclk_fall && !start_det && !stop_det && two_wire) |=> wr2_q ##1 (state_q == ST_WAIT_STOP);
    endproperty
    a_write2: assert property (p_write2) else $error("2-wire write not committed");

    property p_init_delay;
        @(posedge mclk_in) disable iff (!resetn_in)
        $rose(sample_valid_out) |-> adc_enable_in && $past(fs_tick_in) && (init_cnt_q == 2'(ADC_INIT_FS));
    endproperty
    a_init_delay: assert property (p_init_delay) else $error("valid not after two sample periods");

endmodule

/* File: testbench/scp_host_model.sv */
// Host model: drives serial clock, data and strobe of the control port.
// Assumes sda_in is the resolved wire, pulled up when nobody drives it.
`timescale 1ns/1ps
module scp_host_model
(
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output logic      sclk_out,
    output logic      sda_out,
    output logic      strobe_out
);
    initial
    begin
        sclk_out = 1'b0;
        sda_out = 1'b1;
        strobe_out = 1'b0;
    end
    // Four mclk per phase, above the two the port needs
    task automatic ph();
        repeat (4) @(negedge mclk_in);
    endtask
    // Data moves only while clock is low, so no false start
    task automatic bit_out(input logic b);
        sda_out = b;
        ph();
        sclk_out = 1'b1;
        ph();
        sclk_out = 1'b0;
    endtask
    task automatic wr3(input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
            bit_out(w[i]);
        strobe_out = 1'b1;
        ph();
        strobe_out = 1'b0;
        ph();
    endtask
    task automatic wr2(input logic [7:0] a, input logic [15:0] w, output logic [2:0] ack);
        logic [23:0] s;
        s = {a, w};
        sda_out = 1'b1;
        sclk_out = 1'b1;
        ph();
        sda_out = 1'b0;
        ph();
        sclk_out = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            bit_out(s[i]);
            if (i % 8 == 0)
            begin
                sda_out = 1'b1;
                ph();
                sclk_out = 1'b1;
                ph();
                ack[i / 8] = ~sda_in;
                sclk_out = 1'b0;
            end
        end
        sda_out = 1'b0;
        ph();
        sclk_out = 1'b1;
        ph();
        sda_out = 1'b1;
        ph();
    endtask
endmodule

/* File: testbench/tb_scp_top.sv */
// Testbench: both links, pin function and converter start-up.
// Assumes the host model; wire levels are resolved here.
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb_scp_top;
    import scp_pkg::*;
    logic       clk = 0, rst_n = 0, mode = 1, tok = 0, adc_en = 0, fs = 0, pclk = 0, pll_run = 0;
    logic       sclk, hsda, hstb, sda_o, sda_oe, pin_o, pin_oe, bias, pll, osr, valid;
    logic [1:0] mid;
    logic [8:0] conv;
    logic [2:0] ack;
    int         errors = 0, samples_checked = 0;
    wire        sda = hsda & (~sda_oe | sda_o);
    wire        pin = pin_oe ? pin_o : hstb;
    always #12.5 clk = ~clk;
    // Slow PLL clock, eight mclk per period, parked low until needed
    always
    begin
        repeat (4) @(negedge clk);
        pclk = pll_run & ~pclk;
    end
    scp_host_model i_host (.mclk_in(clk), .sda_in(sda), .sclk_out(sclk), .sda_out(hsda), .strobe_out(hstb));
    scp_top i_dut (.mclk_in(clk), .resetn_in(rst_n), .mode_in(mode), .serial_clock_in(sclk),
        .serial_data_line_in(sda), .serial_data_line_out(sda_o), .serial_data_line_oe_out(sda_oe),
        .latch_strobe_pin_in(pin), .latch_strobe_pin_out(pin_o), .latch_strobe_pin_oe_out(pin_oe),
        .temp_ok_in(tok), .automute_active_in(!tok), .pll_clk_in(pclk), .pll_lock_in(tok),
        .adc_enable_in(adc_en), .fs_tick_in(fs), .midrail_impedance_select_out(mid),
        .amp_bias_enable_out(bias), .pll_enable_out(pll), .oversample_select_out(osr),
        .converter_control_out(conv), .sample_valid_out(valid));
    task automatic close_out();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic regs(input logic [8:0] p, input logic [8:0] c);
        `CHK("midrail", p[1:0], mid)
        `CHK("bias", p[3], bias)
        `CHK("pll", p[5], pll)
        `CHK("conv", c, conv)
        `CHK("osr", c[3], osr)
    endtask
    // Cycles between the second and third rise of the pin; first rise may be partial
    task automatic period(input int want);
        int   n, k, r0, r1;
        logic p;
        k = 0;
        r0 = 0;
        r1 = 0;
        p = pin_o;
        for (n = 0; n < 200 && k < 3; n++)
        begin
            @(negedge clk);
            if (pin_o === 1'b1 && p === 1'b0)
            begin
                k++;
                if (k == 2)
                    r0 = n;
                if (k == 3)
                    r1 = n;
            end
            p = pin_o;
        end
        `CHK("clk_out_period", want, r1 - r0)
    endtask
    task automatic tick();
        fs = 1'b1;
        @(negedge clk);
        fs = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        regs(PM1_RESET, CONV_RESET);
        `CHK("valid", 1'b0, valid)
        repeat (2) @(negedge clk);
        i_host.wr3({ADDR_PM1, 9'h12B});
        i_host.wr3({ADDR_CONV, 9'h108});
        regs(9'h12B, 9'h108);
        i_host.wr3({ADDR_SW_RESET, 9'h1FF});
        regs(PM1_RESET, CONV_RESET);
        mode = 1'b0;
        i_host.wr2({BUS_DEV_ADDR, 1'b0}, {ADDR_PM1, 9'h009}, ack);
        `CHK("ack", 3'b111, ack)
        regs(9'h009, CONV_RESET);
        i_host.wr2({BUS_DEV_ADDR ^ 7'h01, 1'b0}, {ADDR_PM1, 9'h000}, ack);
        `CHK("ack", 3'b000, ack)
        i_host.wr2({BUS_DEV_ADDR, 1'b1}, {ADDR_PM1, 9'h000}, ack);
        `CHK("ack", 3'b000, ack)
        regs(9'h009, CONV_RESET);
        tok = 1'b1;
        for (int s = 0; s < 9; s++)
        begin
            // Last pass drops the polarity bit
            i_host.wr2({BUS_DEV_ADDR, 1'b0}, {ADDR_PINFN, 5'h00, s < 8, s[2:0] | {1'b0, s == 8, 1'b0}}, ack);
            `CHK("pin_oe", (s inside {[2:5], 8}), pin_oe)
            if (s inside {[2:5], 8})
                `CHK("pin", !(s inside {2, 5}), pin_o)
        end
        pll_run = 1'b1;
        for (int d = 0; d < 4; d++)
        begin
            i_host.wr2({BUS_DEV_ADDR, 1'b0}, {ADDR_PINFN, 3'h0, d[1:0], 1'b0, 3'h4}, ack);
            period((d + 1) * 8);
        end
        mode = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("pin_oe", 1'b0, pin_oe)
        adc_en = 1'b1;
        tick();
        `CHK("valid", 1'b0, valid)
        tick();
        `CHK("valid", 1'b1, valid)
        close_out();
    end
endmodule
